// ---- rtl/trig_route_pkg.sv ----
// Functional notes
// - Timer-to-timer trigger routes pass in all modes except Stop.
// - Auto-wakeup event triggers second general timer, blocked in Stop.
// - Clock event reaches low-power timer trigger in every mode, Stop included.
// - Selected clock source feeds timer input channel except in Stop.
// - Pins drive timer and converter triggers except Stop; low-power timer always.
// - Peripheral request starts the fast oscillator without software.
// - During Stop the fast oscillator clocks only requesting peripherals.
// - Fast oscillator stops once no requester still needs it.
// - Both serial receivers wake the device on start bit in Stop.
// - Low-power serial receiver may run from the low-speed crystal clock.
// - Standard serial receiver requests or keeps the fast oscillator for wakeup.
// - I2C address match raises a wakeup in Stop mode.
// - I2C reception in Stop requests and keeps the fast oscillator.
package trig_route_pkg;

  // ------------------------------------------------------------
  // Power modes
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    MODE_RUN      = 5'h01,
    MODE_SLEEP    = 5'h02,
    MODE_LP_RUN   = 5'h04,
    MODE_LP_SLEEP = 5'h08,
    MODE_STOP     = 5'h10
  } power_mode_type;

  // ------------------------------------------------------------
  // Oscillator requester indices
  // ------------------------------------------------------------
  localparam int REQ_USART = 0;
  localparam int REQ_LPSR  = 1;
  localparam int REQ_I2C   = 2;
  localparam int REQ_COUNT = 3;

  // Low-power serial receiver clock select codes
  localparam logic LPSR_CLK_FAST = 1'b0;
  localparam logic LPSR_CLK_XTAL = 1'b1;

  // Wakeup reasons from Stop-capable peripherals
  typedef struct packed {
    logic usart_start;
    logic lpsr_start;
    logic lpsr_frame;
    logic i2c_addr;
  } wake_src_type;

  typedef struct packed {
    logic usart_active;
    logic lpsr_active;
    logic i2c_active;
  } osc_req_type;

endpackage : trig_route_pkg

// ---- rtl/osc_demand.sv ----
`timescale 1ns/100ps
`default_nettype none
module osc_demand
  import trig_route_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 resetn_in,
  input  wire logic                 stop_in,
  input  wire logic [REQ_COUNT-1:0] req_in,
  output var  logic                 osc_en_out,
  output var  logic [REQ_COUNT-1:0] feed_out
);

  // ------------------------------------------------------------
  // Demand combine and per-requester gating
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      osc_en_out <= 1'b0;
    end else begin
      osc_en_out <= |req_in;
    end
  end

  // In Stop only requesters are fed; outside Stop all stay fed
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      feed_out <= '0;
    end else if (stop_in) begin
      feed_out <= req_in;
    end else begin
      feed_out <= {REQ_COUNT{1'b1}};
    end
  end

endmodule : osc_demand
`default_nettype wire

// ---- rtl/trig_route.sv ----
`timescale 1ns/100ps
`default_nettype none
module trig_route
  import trig_route_pkg::*;
#(
  parameter int N_TIMERS = 2,
  parameter int N_CLOCKS = 4,
  parameter int N_PINS   = 4,
  parameter int SEL_W    = 2
)(
  input  wire logic                 core_clk_in,
  input  wire logic                 resetn_in,
  input  wire power_mode_type       power_mode_in,
  input  wire logic [N_TIMERS-1:0]  timer_trig_in,
  input  wire logic [SEL_W-1:0]     timer_trig_sel_in,
  input  wire logic                 auto_wakeup_in,
  input  wire logic                 clock_event_in,
  input  wire logic [N_CLOCKS-1:0]  clock_src_in,
  input  wire logic [SEL_W-1:0]     clock_sel_in,
  input  wire logic [N_PINS-1:0]    pins_in,
  input  wire logic [SEL_W-1:0]     timer_pin_sel_in,
  input  wire logic [SEL_W-1:0]     lptim_pin_sel_in,
  input  wire logic [SEL_W-1:0]     conv_pin_sel_in,
  input  wire wake_src_type         wake_src_in,
  input  wire osc_req_type          osc_req_in,
  input  wire logic                 lpsr_clk_sel_in,
  output var  logic [N_TIMERS-1:0]  timer_trig_out,
  output var  logic                 second_timer_trig_out,
  output var  logic                 lptim_trig_out,
  output var  logic                 timer_channel_out,
  output var  logic                 timer_pin_trig_out,
  output var  logic                 lptim_pin_out,
  output var  logic                 conv_trig_out,
  output var  logic                 wakeup_irq_out,
  output var  wake_src_type         wake_cause_out,
  output var  logic                 osc_en_out,
  output var  logic [REQ_COUNT-1:0] osc_feed_out,
  output var  logic                 lpsr_use_xtal_out
);

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  logic stop_mode;
  logic run_like;

  function automatic logic pick(input logic [31:0] v, input logic [SEL_W-1:0] s);
    pick = v[s];
  endfunction : pick

  assign stop_mode = (power_mode_in == MODE_STOP);
  assign run_like  = (power_mode_in == MODE_RUN) || (power_mode_in == MODE_SLEEP) ||
                     (power_mode_in == MODE_LP_RUN) || (power_mode_in == MODE_LP_SLEEP);

  // ------------------------------------------------------------
  // Trigger routes
  // ------------------------------------------------------------
  // Every timer is triggered by the one selected timer (same select for all, itself included); blocked in Stop
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_trig_out <= '0;
    end else begin
      for (int i = 0; i < N_TIMERS; i++) begin
        timer_trig_out[i] <= run_like && pick(32'(timer_trig_in), timer_trig_sel_in);
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      second_timer_trig_out <= 1'b0;
      lptim_trig_out        <= 1'b0;
    end else begin
      second_timer_trig_out <= run_like && auto_wakeup_in;
      lptim_trig_out        <= (run_like || stop_mode) && clock_event_in;
    end
  end

  // Clock sampled by the core clock: only useful for sources well below 50 MHz
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_channel_out <= 1'b0;
    end else begin
      timer_channel_out <= run_like && pick(32'(clock_src_in), clock_sel_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timer_pin_trig_out <= 1'b0;
      lptim_pin_out      <= 1'b0;
      conv_trig_out      <= 1'b0;
    end else begin
      timer_pin_trig_out <= run_like && pick(32'(pins_in), timer_pin_sel_in);
      lptim_pin_out      <= (run_like || stop_mode) && pick(32'(pins_in), lptim_pin_sel_in);
      conv_trig_out      <= run_like && pick(32'(pins_in), conv_pin_sel_in);
    end
  end

  // ------------------------------------------------------------
  // Stop-mode wakeup
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wakeup_irq_out <= 1'b0;
      wake_cause_out <= '0;
    end else begin
      wake_cause_out <= stop_mode ? wake_src_in : '0;
      wakeup_irq_out <= stop_mode && (|wake_src_in);
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lpsr_use_xtal_out <= 1'b0;
    end else begin
      lpsr_use_xtal_out <= (lpsr_clk_sel_in == LPSR_CLK_XTAL);
    end
  end

  // ------------------------------------------------------------
  // Fast oscillator on demand
  // ------------------------------------------------------------
  logic [REQ_COUNT-1:0] req_vec;

  // Crystal-clocked low-power receiver never needs the fast oscillator
  always_comb begin
    req_vec            = '0;
    req_vec[REQ_USART] = osc_req_in.usart_active;
    req_vec[REQ_LPSR]  = osc_req_in.lpsr_active && (lpsr_clk_sel_in == LPSR_CLK_FAST);
    req_vec[REQ_I2C]   = osc_req_in.i2c_active;
  end

  osc_demand u_osc_demand (
    .core_clk_in (core_clk_in),
    .resetn_in   (resetn_in),
    .stop_in     (stop_mode),
    .req_in      (req_vec),
    .osc_en_out  (osc_en_out),
    .feed_out    (osc_feed_out)
  );

endmodule : trig_route
`default_nettype wire

// ---- test/trig_route_props.sv ----
`timescale 1ns/100ps
`default_nettype none
module trig_route_props
  import trig_route_pkg::*;
(
  input wire logic                 core_clk_in,
  input wire logic                 resetn_in,
  input wire power_mode_type       power_mode_in,
  input wire logic                 auto_wakeup_in,
  input wire logic                 clock_event_in,
  input wire wake_src_type         wake_src_in,
  input wire osc_req_type          osc_req_in,
  input wire logic                 lpsr_clk_sel_in,
  input wire logic                 second_timer_trig_out,
  input wire logic                 lptim_trig_out,
  input wire logic                 wakeup_irq_out,
  input wire logic                 osc_en_out,
  input wire logic [REQ_COUNT-1:0] osc_feed_out,
  input wire logic                 lpsr_use_xtal_out
);
  logic                 armed_reg;
  wire logic            rl = power_mode_in inside {MODE_RUN, MODE_SLEEP, MODE_LP_RUN, MODE_LP_SLEEP};
  wire logic            st = power_mode_in == MODE_STOP;
  wire logic [REQ_COUNT-1:0] rv = {osc_req_in.i2c_active, osc_req_in.lpsr_active & !lpsr_clk_sel_in,
                                   osc_req_in.usart_active};
  // First edge out of reset still shows reset-time outputs, so checks wait one edge
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) armed_reg <= 1'b0;
    else armed_reg <= 1'b1;
  end
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence awu_run_s;
    auto_wakeup_in && rl ##1 armed_reg;
  endsequence
  awu_run_a: assert property (awu_run_s |-> second_timer_trig_out) else $error("wakeup trigger lost");
  awu_stop_a: assert property (armed_reg && $past(st) |-> !second_timer_trig_out) else $error("stop leak");
  lptim_evt_a: assert property (armed_reg |->
    lptim_trig_out == ($past(clock_event_in) && ($past(rl) || $past(st)))) else $error("lptim event wrong");
  wake_irq_a: assert property (armed_reg |->
    wakeup_irq_out == ($past(st) && |$past(wake_src_in))) else $error("wakeup irq wrong");
  osc_on_a: assert property (armed_reg && $past(|rv) |-> osc_en_out) else $error("osc not on");
  osc_off_a: assert property (armed_reg && !$past(|rv) |-> !osc_en_out) else $error("osc left on");
  stop_feed_a: assert property (armed_reg && $past(st) |->
    osc_feed_out == $past(rv)) else $error("feed wrong");
  run_feed_a: assert property (armed_reg && !$past(st) |->
    &osc_feed_out) else $error("feed not all on outside stop");
  xtal_sel_a: assert property (armed_reg |->
    lpsr_use_xtal_out == $past(lpsr_clk_sel_in)) else $error("xtal");
endmodule : trig_route_props
bind trig_route trig_route_props u_props (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in), .power_mode_in(power_mode_in),
  .auto_wakeup_in(auto_wakeup_in), .clock_event_in(clock_event_in), .wake_src_in(wake_src_in),
  .osc_req_in(osc_req_in), .lpsr_clk_sel_in(lpsr_clk_sel_in), .second_timer_trig_out(second_timer_trig_out),
  .lptim_trig_out(lptim_trig_out), .wakeup_irq_out(wakeup_irq_out), .osc_en_out(osc_en_out),
  .osc_feed_out(osc_feed_out), .lpsr_use_xtal_out(lpsr_use_xtal_out)
);
`default_nettype wire

// ---- test/periph_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module periph_model
  import trig_route_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic [2:0]           busy_in,
  input  wire logic                 osc_en_in,
  input  wire logic [REQ_COUNT-1:0] feed_in,
  output var  osc_req_type          req_out,
  output var  logic [REQ_COUNT-1:0] ticks_out
);
  // A receiver's request follows its busy input directly; no frame is modelled
  always_comb req_out = {busy_in[0], busy_in[1], busy_in[2]};
  // Clock each peripheral actually sees
  always_ff @(posedge core_clk_in) ticks_out <= osc_en_in ? feed_in : '0;
endmodule : periph_model
`default_nettype wire

// ---- test/lowpower_trigger_wakeup_routing_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module lowpower_trigger_wakeup_routing_tb;
  import trig_route_pkg::*;
  typedef struct packed {power_mode_type m; logic [2:0] b; logic l; logic [8:0] t; logic [4:0] o;} row_type;
  localparam row_type ROWS [10] = '{
    '{MODE_RUN, 3'h0, 1'b0, 9'h1FE, 5'h07}, '{MODE_SLEEP, 3'h1, 1'b0, 9'h1FE, 5'h0F},
    '{MODE_LP_RUN, 3'h0, 1'b0, 9'h1FE, 5'h07}, '{MODE_LP_SLEEP, 3'h0, 1'b0, 9'h1FE, 5'h07},
    '{MODE_STOP, 3'h4, 1'b0, 9'h025, 5'h0C}, '{MODE_STOP, 3'h3, 1'b0, 9'h025, 5'h0B},
    '{MODE_STOP, 3'h2, 1'b1, 9'h025, 5'h10}, '{MODE_STOP, 3'h0, 1'b0, 9'h025, 5'h00},
    '{power_mode_type'(5'h00), 3'h0, 1'b0, 9'h000, 5'h07}, '{power_mode_type'(5'h03), 3'h0, 1'b0, 9'h000, 5'h07}};
  logic           clk = 1'b0;
  logic           rstn = 1'b0;
  power_mode_type mode = MODE_RUN;
  logic [1:0]     sel = 2'h1;
  logic [3:0]     pins = 4'h2;
  logic           awu = 1'b1;
  logic           cev = 1'b1;
  logic           lsel = 1'b0;
  logic [2:0]     busy = 3'h0;
  wake_src_type   ws = 4'h1;
  logic [1:0]     tto;
  logic           s2, lpt, chn, ptr, lpp, cnv, irq, en, xt;
  logic [2:0]     fd, tk;
  wake_src_type   wc;
  osc_req_type    rq;
  int             fail_count = 0;
  int             cmp_count = 0;
  always #5 clk = ~clk;
  trig_route dut (.core_clk_in(clk), .resetn_in(rstn), .power_mode_in(mode), .timer_trig_in(2'h2),
    .timer_trig_sel_in(sel), .auto_wakeup_in(awu), .clock_event_in(cev), .clock_src_in(4'h2), .clock_sel_in(sel),
    .pins_in(pins), .timer_pin_sel_in(sel), .lptim_pin_sel_in(sel), .conv_pin_sel_in(sel), .wake_src_in(ws),
    .osc_req_in(rq), .lpsr_clk_sel_in(lsel), .timer_trig_out(tto), .second_timer_trig_out(s2),
    .lptim_trig_out(lpt), .timer_channel_out(chn), .timer_pin_trig_out(ptr), .lptim_pin_out(lpp),
    .conv_trig_out(cnv), .wakeup_irq_out(irq), .wake_cause_out(wc), .osc_en_out(en), .osc_feed_out(fd),
    .lpsr_use_xtal_out(xt));
  periph_model partner (.core_clk_in(clk), .busy_in(busy), .osc_en_in(en), .feed_in(fd), .req_out(rq),
    .ticks_out(tk));
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] s);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Whole run is under 60 cycles; this leaves a wide margin
  initial begin
    #5000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    foreach (ROWS[i]) begin
      @(negedge clk);
      mode = ROWS[i].m;
      busy = ROWS[i].b;
      lsel = ROWS[i].l;
      @(negedge clk);
      chk("routes", ROWS[i].t, {tto, s2, lpt, chn, ptr, lpp, cnv, irq});
      chk("osc", {4'h0, ROWS[i].o}, {4'h0, xt, en, fd});
    end
    mode = MODE_RUN;
    sel = 2'h0;
    pins = 4'h1;
    awu = 1'b0;
    cev = 1'b0;
    @(negedge clk);
    chk("sel0", 9'h00E, {tto, s2, lpt, chn, ptr, lpp, cnv, irq});
    mode = MODE_STOP;
    busy = 3'h4;
    repeat (2) @(negedge clk);
    chk("ticks", 9'h004, {6'h0, tk});
    chk("cause", 9'h001, {5'h0, wc});
    ws = 4'hC;
    @(negedge clk);
    chk("start", 9'h01C, {4'h0, irq, wc});
    mode = MODE_RUN;
    @(negedge clk);
    chk("runwake", 9'h000, {4'h0, irq, wc});
    rstn = 1'b0;
    @(negedge clk);
    chk("reset", 9'h000, {tto, s2, lpt, chn, ptr, lpp, cnv, irq});
    chk("rstosc", 9'h000, {4'h0, xt, en, fd});
    summarize();
  end
endmodule : lowpower_trigger_wakeup_routing_tb
`default_nettype wire
